// ---- sa6_irq_regs.vh ----
// register map and constants for the sa6 pattern change status block
//
// Behaviour
// - Bit 2 sets when the debounced sa6 code enters 001x and when it leaves 001x, lowest bit ignored.
// - Bit 1 sets when the debounced code enters a code matching none of the monitored patterns, not when it leaves or moves among such codes.
// - Bit 0 sets when the debounced code enters 0000 and when it leaves 0000.
// - Status bits reset to 0, show events since the last read, and clear when the register is read.
// - The interrupt rises only for events whose enable bit is set; status records events regardless.
// - Bits 7 to 3 flag entry into and exit from 1111, 1110, 1100, 1010 and 1000 like bit 0.
`ifndef SA6_IRQ_REGS_VH
`define SA6_IRQ_REGS_VH

`define SA6_ADDR_W         2
`define SA6_STATUS_ADDR    2'h0
`define SA6_ENABLE_ADDR    2'h1
`define SA6_CODE_ADDR      2'h2
`define SA6_STATUS_RESET   8'h00
`define SA6_ENABLE_RESET   8'h00
`define SA6_CODE_RESET     4'h0
`define SA6_MATCH_RESET    8'h01

`define SA6_BIT_ALL_ZERO   0
`define SA6_BIT_UNLISTED   1
`define SA6_BIT_001X       2
`define SA6_BIT_1000       3
`define SA6_BIT_1010       4
`define SA6_BIT_1100       5
`define SA6_BIT_1110       6
`define SA6_BIT_1111       7

`define SA6_PAT_0000       4'h0
`define SA6_PAT_001X       3'h1
`define SA6_PAT_1000       4'h8
`define SA6_PAT_1010       4'hA
`define SA6_PAT_1100       4'hC
`define SA6_PAT_1110       4'hE
`define SA6_PAT_1111       4'hF

`endif

// ---- sa6_pattern_irq.v ----
// sa6 pattern change status flags, enables and interrupt for one e1 receive channel
//
// Added by the designer: the register offsets and the address-and-strobe port.
`include "sa6_irq_regs.vh"

module sa6_pattern_irq (
    input  wire                   clk_i,
    input  wire                   reset_i,
    input  wire [3:0]             sa6_debounced_i,
    input  wire                   sa6_update_i,
    input  wire [`SA6_ADDR_W-1:0] addr_i,
    input  wire [7:0]             wdata_i,
    input  wire                   write_i,
    input  wire                   read_i,
    output reg  [7:0]             rdata_o,
    output wire                   irq_o
);

    localparam [7:0] STATUS_RESET = `SA6_STATUS_RESET;
    localparam [7:0] ENABLE_RESET = `SA6_ENABLE_RESET;
    localparam [7:0] MATCH_RESET  = `SA6_MATCH_RESET;
    localparam [3:0] CODE_RESET   = `SA6_CODE_RESET;

    // stored state
    reg  [3:0] sa6_code;
    reg  [3:0] next_sa6_code;
    reg  [7:0] match_prev;
    reg  [7:0] next_match_prev;
    reg  [7:0] sa6_pattern_irq_enable;
    reg  [7:0] next_enable;
    reg  [7:0] next_rdata;

    // decoded view of the code now on the input
    reg  [7:0] match_now;
    wire [7:0] event_now;
    wire [7:0] sa6_pattern_change_status;
    wire [7:0] pending;

    // bus decode
    wire       status_read;
    wire       enable_write;

    genvar g;

    // one-hot class of the incoming code; codes outside the list land on bit 1
    always @* begin
        match_now = 8'h00;
        case (sa6_debounced_i)
            `SA6_PAT_0000: begin
                match_now[`SA6_BIT_ALL_ZERO] = 1'b1;
            end
            {`SA6_PAT_001X, 1'b0}: begin
                match_now[`SA6_BIT_001X] = 1'b1;
            end
            {`SA6_PAT_001X, 1'b1}: begin
                match_now[`SA6_BIT_001X] = 1'b1;
            end
            `SA6_PAT_1000: begin
                match_now[`SA6_BIT_1000] = 1'b1;
            end
            `SA6_PAT_1010: begin
                match_now[`SA6_BIT_1010] = 1'b1;
            end
            `SA6_PAT_1100: begin
                match_now[`SA6_BIT_1100] = 1'b1;
            end
            `SA6_PAT_1110: begin
                match_now[`SA6_BIT_1110] = 1'b1;
            end
            `SA6_PAT_1111: begin
                match_now[`SA6_BIT_1111] = 1'b1;
            end
            default: begin
                match_now[`SA6_BIT_UNLISTED] = 1'b1;
            end
        endcase
    end

    // writes to the status and code addresses fall through unused
    assign status_read  = read_i & (addr_i == `SA6_STATUS_ADDR);
    assign enable_write = write_i & (addr_i == `SA6_ENABLE_ADDR);

    // one status flag per class; a same-cycle event survives the read clear
    generate
        for (g = 0; g < 8; g = g + 1) begin : gen_flag
            reg  flag;
            reg  next_flag;
            wire change;

            if (g == `SA6_BIT_UNLISTED) begin : gen_entry
                // entry only, so wandering among unlisted codes stays quiet
                assign change = match_now[g] & ~match_prev[g];
            end else begin : gen_both
                assign change = match_now[g] ^ match_prev[g];
            end

            assign event_now[g] = sa6_update_i & change;

            always @* begin
                next_flag = flag;
                if (status_read) begin
                    next_flag = 1'b0;
                end
                if (event_now[g]) begin
                    next_flag = 1'b1;
                end
            end

            always @(posedge clk_i) begin
                if (reset_i) begin
                    flag <= STATUS_RESET[g];
                end else begin
                    flag <= next_flag;
                end
            end

            assign sa6_pattern_change_status[g] = flag;
            assign pending[g] = flag & sa6_pattern_irq_enable[g];
        end
    endgenerate

    always @* begin
        next_enable = sa6_pattern_irq_enable;
        if (enable_write) begin
            next_enable = wdata_i;
        end
    end

    always @(posedge clk_i) begin
        if (reset_i) begin
            sa6_pattern_irq_enable <= ENABLE_RESET;
        end else begin
            sa6_pattern_irq_enable <= next_enable;
        end
    end

    // the previous class moves only on an update, so idle cycles are never judged again
    always @* begin
        next_sa6_code   = sa6_code;
        next_match_prev = match_prev;
        if (sa6_update_i) begin
            next_sa6_code   = sa6_debounced_i;
            next_match_prev = match_now;
        end
    end

    // after reset the previous code counts as 0000, so a first non-zero update flags bit 0
    always @(posedge clk_i) begin
        if (reset_i) begin
            sa6_code   <= CODE_RESET;
            match_prev <= MATCH_RESET;
        end else begin
            sa6_code   <= next_sa6_code;
            match_prev <= next_match_prev;
        end
    end

    // read data stand one cycle and fall back to zero, so no value is taken twice
    always @* begin
        next_rdata = 8'h00;
        if (read_i) begin
            case (addr_i)
                `SA6_STATUS_ADDR: begin
                    next_rdata = sa6_pattern_change_status;
                end
                `SA6_ENABLE_ADDR: begin
                    next_rdata = sa6_pattern_irq_enable;
                end
                `SA6_CODE_ADDR: begin
                    next_rdata = {4'h0, sa6_code};
                end
                default: begin
                    next_rdata = 8'h00;
                end
            endcase
        end
    end

    always @(posedge clk_i) begin
        if (reset_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= next_rdata;
        end
    end

    // status always latches; only the enable gates the line
    assign irq_o = |pending;

endmodule // sa6_pattern_irq

// ---- sa6_pattern_irq_assertions.sv ----
// assertions for the sa6 pattern status block
module sa6_pattern_irq_checker (input wire logic clk_i, reset_i, sa6_update_i, write_i, read_i,
    irq_o, input wire logic [3:0] sa6_debounced_i, input wire logic [1:0] addr_i,
    input wire logic [7:0] wdata_i, rdata_o);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    a_rd_idle: assert property (!$past(read_i) |-> rdata_o == 8'h00)
        else $error("read data not zero without a read");
    a_rst_zero: assert property ($past(reset_i) |-> rdata_o == 8'h00 && !irq_o)
        else $error("outputs not zero after reset");
    a_rc_clear: assert property (read_i && addr_i == 2'h0 && !sa6_update_i
        ##1 read_i && addr_i == 2'h0 |=> rdata_o == 8'h00) else $error("status not cleared");
    a_en_block: assert property (read_i && addr_i == 2'h1 ##1 rdata_o == 8'h00 |-> !irq_o)
        else $error("interrupt with all enables off");
    a_en_back: assert property (write_i && addr_i == 2'h1 ##1 read_i && addr_i == 2'h1
        |=> rdata_o == $past(wdata_i, 2)) else $error("enable read back wrong");
    a_code_back: assert property (sa6_update_i ##1 read_i && addr_i == 2'h2
        |=> rdata_o == $past(sa6_debounced_i, 2)) else $error("code read back wrong");
    a_addr3_zero: assert property (read_i && addr_i == 2'h3 |=> rdata_o == 8'h00)
        else $error("unused address read not zero");
    a_irq_hold: assert property (!sa6_update_i && !(write_i && addr_i == 2'h1)
        && !(read_i && addr_i == 2'h0) |=> $stable(irq_o)) else $error("interrupt moved");
    cover property (irq_o);
    cover property (sa6_update_i && read_i && !addr_i);
    cover property (read_i && !addr_i ##1 rdata_o);
endmodule // sa6_pattern_irq_checker
bind sa6_pattern_irq sa6_pattern_irq_checker u_chk (.*);

// ---- sa6_pattern_irq_bench.sv ----
// random bench with a reference model for the sa6 pattern status block
module sa6_pattern_irq_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, reset_i = 1, sa6_update_i = 0, write_i = 0, read_i = 0, irq_o;
    logic [1:0] addr_i = 0;
    logic [3:0] sa6_debounced_i = 0, cd = 0;
    logic [7:0] wdata_i = 0, st = 0, en = 0, rq = 0, rdata_o;
    int err_count = 0, total_checks = 0, pc = 0, nc, k;
    sa6_pattern_irq u_dut (
        .clk_i           (clk_i),
        .reset_i         (reset_i),
        .sa6_debounced_i (sa6_debounced_i),
        .sa6_update_i    (sa6_update_i),
        .addr_i          (addr_i),
        .wdata_i         (wdata_i),
        .write_i         (write_i),
        .read_i          (read_i),
        .rdata_o         (rdata_o),
        .irq_o           (irq_o)
    );
    initial forever #20 clk_i = ~clk_i;
    task automatic chk_rdata(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t rdata got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_irq(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t irq got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // model reads inputs before the bench's nonblocking updates land, like the design
    always @(posedge clk_i) begin
        case (sa6_debounced_i)
            4'h0: nc = 0;
            4'h2, 4'h3: nc = 2;
            4'h8: nc = 3;
            4'hA: nc = 4;
            4'hC: nc = 5;
            4'hE: nc = 6;
            4'hF: nc = 7;
            default: nc = 1;
        endcase
        rq = 8'h00;
        if (read_i && addr_i == 2'h0) rq = st;
        if (read_i && addr_i == 2'h1) rq = en;
        if (read_i && addr_i == 2'h2) rq = {4'h0, cd};
        if (read_i && addr_i == 2'h0) st = 8'h00;
        if (write_i && addr_i == 2'h1) en = wdata_i;
        if (sa6_update_i && nc != pc) st[nc] = 1'b1;
        if (sa6_update_i && nc != pc && pc != 1) st[pc] = 1'b1;
        if (sa6_update_i) {pc, cd} = {nc, sa6_debounced_i};
        if (reset_i) {st, en, rq, cd, pc} = 0;
    end
    always @(negedge clk_i) begin
        chk_rdata(rdata_o, rq);
        chk_irq(irq_o, |(st & en));
    end
    initial begin
        k = $urandom(32'hED6DD4D7);
        repeat (10) @(posedge clk_i);
        repeat (6000) begin
            k = $urandom;
            {reset_i, wdata_i, addr_i, sa6_debounced_i, sa6_update_i} <= {k[31:25] == 0, k[14:0]};
            {write_i, read_i} <= {k[16:15] == 1, k[16]};
            @(posedge clk_i);
        end
        $display("random run done");
        end_of_test;
    end
    initial begin
        #280000;
        err_count++;
        end_of_test;
    end
endmodule // sa6_pattern_irq_bench
